//--- tb_uncorr_err_regs.sv
// self-checking bench of the uncorrectable-error register bank
`timescale 1ns/10ps
`default_nettype none
module tb_uncorr_err_regs;
    logic                          clk_sys;
    logic                          resetn;
    logic                          pwr_rstn;
    logic                          wr_stb;
    logic                          rd_stb;
    logic [11:0]                   addr;
    logic [31:0]                   wdata;
    logic [31:0]                   rdata;
    logic                          irq;
    uncorr_err_pkg::err_event_type err_event;
    uncorr_err_pkg::ack_nak_type   ack_nak;
    uncorr_err_pkg::err_msg_type   err_msg;
    int                            failures = 0;
    int                            n_compared = 0;
    localparam logic [127:0] H1 = 128'h0123456789ABCDEFFEDCBA9876543210;
    localparam logic [127:0] H2 = 128'hA5A5A5A55A5A5A5AC3C3C3C33C3C3C3C;
    localparam logic [11:0]  FL = uncorr_err_pkg::OFS_FLAGS;
    localparam logic [11:0]  MK = uncorr_err_pkg::OFS_REPORT_MASK;
    localparam logic [11:0]  SV = uncorr_err_pkg::OFS_FATAL_SELECT;

    uncorr_err_regs i_dut (.clk_sys(clk_sys), .resetn(resetn),
        .pwr_rstn(pwr_rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .err_event(err_event),
        .ack_nak(ack_nak), .err_msg(err_msg), .irq(irq));
    uncorr_link_model i_link (.clk_sys(clk_sys), .err_event(err_event),
        .ack_nak(ack_nak));

    //------------------------------------------------------------------
    // shared tasks
    //------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        addr   <= a;
        wdata  <= v;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        @(posedge clk_sys);
        chk(rdata, exp);
    endtask
    // message pulse is looked at in the cycle after the event is taken
    task automatic evc(input logic [31:0] b, input logic [127:0] h,
                       input logic [1:0] msg);
        i_link.send_err(b, h);
        @(posedge clk_sys);
        chk({30'h0, err_msg}, {30'h0, msg});
    endtask
    task automatic conclude();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    //------------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------------
    task automatic t_reset();
        rdc(FL, 32'h00000000);
        rdc(MK, 32'h00000000);
        rdc(SV, 32'h00062011);
        wr(MK, 32'hFFFFFFFF);
        rdc(MK, 32'h0017F010);
        wr(SV, 32'hFFFFFFFF);
        rdc(SV, 32'h0017F011);
        wr(SV, 32'h00000000);
        rdc(SV, uncorr_err_pkg::SEV_RO_ONE);
        wr(FL, 32'hFFFFFFFF);
        rdc(FL, 32'h00000000);
        wr(12'h200, 32'hFFFFFFFF);
        rdc(12'h200, 32'h00000000);
        wr(MK, 32'h00000000);
        wr(SV, 32'h00062011);
        $display("test reset_values done");
    endtask
    task automatic t_poison();
        evc(32'h00080001, H2, 2'b00);
        rdc(FL, 32'h00000000);
        evc(32'h00001000, H1, 2'b01);
        rdc(FL, 32'h00001000);
        for (int i = 0; i < 4; i++)
            rdc(uncorr_err_pkg::OFS_HDR_LOG0 + 12'(4 * i),
                H1[32 * i +: 32]);
        wr(SV, 32'h00063011);
        evc(32'h00001000, H2, 2'b10);
        rdc(uncorr_err_pkg::OFS_HDR_LOG0, H1[31:0]);
        wr(FL, 32'h00000000);
        rdc(FL, 32'h00001000);
        wr(FL, 32'h00001000);
        rdc(FL, 32'h00000000);
        wr(SV, 32'h00062011);
        $display("test poisoned done");
    endtask
    task automatic t_dlp();
        logic [11:0] s[7] = '{12'd15, 12'd10, 12'd20, 12'd9, 12'd2,
                              12'd4091, 12'd6};
        logic [11:0] a[7] = '{12'd10, 12'd10, 12'd10, 12'd10, 12'd4090,
                              12'd4090, 12'd4090};
        logic [11:0] n[7] = '{12'd20, 12'd20, 12'd20, 12'd20, 12'd5,
                              12'd5, 12'd5};
        logic        bad[7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 7; i++)
        begin
            i_link.send_ack(s[i], a[i], n[i]);
            @(posedge clk_sys);
            chk({30'h0, err_msg}, {30'h0, bad[i], 1'b0});
            rdc(FL, {27'h0, bad[i], 4'h0});
            wr(FL, 32'h00000010);
        end
        $display("test link_protocol done");
    endtask
    task automatic t_mask();
        wr(MK, 32'h00001000);
        evc(32'h00001000, H2, 2'b00);
        rdc(FL, 32'h00001000);
        wr(FL, 32'h00001000);
        wr(MK, 32'h00000000);
        $display("test mask done");
    endtask
    task automatic t_set_wins();
        fork
            wr(FL, 32'h00001000);
            i_link.send_err(32'h00001000, H2);
        join
        rdc(FL, 32'h00001000);
        wr(FL, 32'h00001000);
        rdc(FL, 32'h00000000);
        $display("test set_wins done");
    endtask
    task automatic t_irq();
        wr(uncorr_err_pkg::OFS_IRQ_STATUS, 32'h00000003);
        wr(uncorr_err_pkg::OFS_IRQ_MASK, 32'h00000000);
        evc(32'h00001000, H1, 2'b01);
        chk({31'h0, irq}, 32'h0);
        rdc(uncorr_err_pkg::OFS_IRQ_STATUS, 32'h00000002);
        wr(uncorr_err_pkg::OFS_IRQ_MASK, 32'h00000002);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        wr(uncorr_err_pkg::OFS_IRQ_STATUS, 32'h00000002);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        wr(FL, 32'h00001000);
        $display("test interrupt done");
    endtask
    task automatic t_sticky();
        wr(MK, 32'h00000010);
        wr(SV, 32'h00001000);
        evc(32'h00001000, H1, 2'b10);
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        rdc(FL, 32'h00001000);
        rdc(MK, 32'h00000010);
        rdc(SV, 32'h00001001);
        $display("test sticky done");
    endtask

    //------------------------------------------------------------------
    // clock, reset, sequence and watchdog
    //------------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        resetn = 1'b0;
        pwr_rstn = 1'b0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        addr = 12'h000;
        wdata = 32'h00000000;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        pwr_rstn <= 1'b1;
        t_reset();
        t_poison();
        t_dlp();
        t_mask();
        t_set_wins();
        t_irq();
        t_sticky();
        conclude();
    end
    initial
    begin
        #200000;
        failures++;
        conclude();
    end
endmodule
`default_nettype wire

//--- uncorr_err_pkg.sv
// constants, field layouts and carriers of the uncorrectable-error registers
`default_nettype none
package uncorr_err_pkg;

    //--------------------------------------------------------------------
    // register map (byte addresses)
    //--------------------------------------------------------------------
    localparam int          ADDR_W              = 12;
    localparam logic [11:0] OFS_FLAGS           = 12'h104;
    localparam logic [11:0] OFS_REPORT_MASK     = 12'h108;
    localparam logic [11:0] OFS_FATAL_SELECT    = 12'h10C;
    localparam logic [11:0] OFS_HDR_LOG0        = 12'h11C;
    localparam logic [11:0] OFS_IRQ_STATUS      = 12'h140;
    localparam logic [11:0] OFS_IRQ_MASK        = 12'h144;

    //--------------------------------------------------------------------
    // field layout
    //--------------------------------------------------------------------
    localparam logic [31:0] IMPL_BITS           = 32'h0017F010;
    localparam logic [31:0] HDR_LOG_BITS        = 32'h00179000;
    localparam logic [31:0] MASK_RESET          = 32'h00000000;
    localparam logic [31:0] SEV_RESET           = 32'h00062011;
    localparam logic [31:0] SEV_RO_ONE          = 32'h00000001;
    localparam logic [31:0] FLAGS_RESET         = 32'h00000000;
    localparam int          BIT_POISONED        = 12;
    localparam int          BIT_DL_PROTOCOL     = 4;
    localparam int          BIT_TRAINING        = 0;
    localparam int          BIT_ECRC            = 19;
    localparam int          HDR_WORDS           = 4;
    localparam int          SEQ_W               = 12;

    // interrupt status layout
    localparam int          IRQ_W               = 2;
    localparam int          IRQ_FATAL           = 0;
    localparam int          IRQ_NONFATAL        = 1;
    localparam logic [1:0]  IRQ_RESET           = 2'h0;

    //--------------------------------------------------------------------
    // carriers
    //--------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [31:0] bits;
        logic [127:0] header;
    } err_event_type;

    typedef struct packed {
        logic        valid;
        logic [11:0] seq;
        logic [11:0] acked_seq;
        logic [11:0] next_tx_seq;
    } ack_nak_type;

    typedef struct packed {
        logic fatal;
        logic nonfatal;
    } err_msg_type;

endpackage
`default_nettype wire

//--- uncorr_err_regs.sv
// uncorrectable-error flags, report mask, fatal select and header log
//
// Function
// - set flag bit 12 when a received packet carries a poisoned payload
// - first uncorrectable error recorded captures the offending header if it is a header-logging one (bits 12, 15-18, 20)
// - set flag bit 4 when ACK/NAK names no outstanding or last-acked packet
// - flags clear only where software writes one; zero leaves them
// - flags survive ordinary reset; only power-on clears them
// - bit 0 flag reads zero; its mask and severity bits are read-only
// - masked error sends no message to the root complex
// - masked error still sets its flag
// - one mask bit beside every implemented flag bit
// - writable mask bits reset to zero, zero reports, one masks
// - ECRC mask bit 19 reads zero; its severity bit is read-only
// - severity bit set reports fatal, clear reports nonfatal
// - severity resets fatal for bits 18, 17, 13, 4 and 0, others nonfatal
// - mask and severity keep programmed values across ordinary reset
`timescale 1ns/10ps
`default_nettype none
module uncorr_err_regs
(
    // clock and resets
    input  wire logic                               clk_sys,
    input  wire logic                               resetn,
    input  wire logic                               pwr_rstn,
    // register port
    input  wire logic [uncorr_err_pkg::ADDR_W-1:0]  addr,
    input  wire logic [31:0]                        wdata,
    input  wire logic                               wr_stb,
    input  wire logic                               rd_stb,
    output logic      [31:0]                        rdata,
    // error events from the link logic
    input  wire uncorr_err_pkg::err_event_type      err_event,
    input  wire uncorr_err_pkg::ack_nak_type        ack_nak,
    // messages and interrupt
    output uncorr_err_pkg::err_msg_type             err_msg,
    output logic                                    irq
);

    //--------------------------------------------------------------------
    // state
    //--------------------------------------------------------------------
    logic [31:0]                        flags_reg;
    logic [31:0]                        flags_next;
    logic [31:0]                        mask_reg;
    logic [31:0]                        mask_next;
    logic [31:0]                        sev_reg;
    logic [31:0]                        sev_next;
    logic [127:0]                       hdr_reg;
    logic [127:0]                       hdr_next;
    logic [uncorr_err_pkg::IRQ_W-1:0]   irq_sts_reg;
    logic [uncorr_err_pkg::IRQ_W-1:0]   irq_sts_next;
    logic [uncorr_err_pkg::IRQ_W-1:0]   irq_msk_reg;
    logic [31:0]                        rdata_reg;
    logic [31:0]                        rdata_next;
    uncorr_err_pkg::err_msg_type        msg_reg;
    uncorr_err_pkg::err_msg_type        msg_next;
    logic                               irq_reg;

    //--------------------------------------------------------------------
    // address decode
    //--------------------------------------------------------------------
    wire logic sel_flags = (addr == uncorr_err_pkg::OFS_FLAGS);
    wire logic sel_mask  = (addr == uncorr_err_pkg::OFS_REPORT_MASK);
    wire logic sel_sev   = (addr == uncorr_err_pkg::OFS_FATAL_SELECT);
    wire logic sel_imsk  = (addr == uncorr_err_pkg::OFS_IRQ_MASK);
    wire logic sel_ists  = (addr == uncorr_err_pkg::OFS_IRQ_STATUS);

    wire logic wr_flags  = wr_stb && sel_flags;
    wire logic wr_mask   = wr_stb && sel_mask;
    wire logic wr_sev    = wr_stb && sel_sev;
    wire logic wr_imsk   = wr_stb && sel_imsk;
    wire logic wr_ists   = wr_stb && sel_ists;

    // header log words sit at four consecutive words
    localparam int HDRW = uncorr_err_pkg::HDR_WORDS;
    logic [HDRW-1:0] sel_hdr;
    logic [31:0] hdr_word [HDRW];
    genvar gi;
    generate
        for (gi = 0; gi < HDRW; gi = gi + 1)
        begin : g_hdr
            assign sel_hdr[gi] = (addr == uncorr_err_pkg::OFS_HDR_LOG0
                                  + 12'(4 * gi));
            assign hdr_word[gi] = hdr_reg[32*gi +: 32];
        end
    endgenerate

    //--------------------------------------------------------------------
    // ack/nak sequence check
    //--------------------------------------------------------------------
    // distance from the last acked number; valid up to the outstanding count
    wire logic [11:0] seq_dist  = ack_nak.seq - ack_nak.acked_seq;
    wire logic [11:0] seq_span  = ack_nak.next_tx_seq - ack_nak.acked_seq;
    wire logic        ack_bad   = ack_nak.valid && (seq_dist >= seq_span)
                                  && (seq_dist != 12'h000);

    //--------------------------------------------------------------------
    // new errors, logging and reporting
    //--------------------------------------------------------------------
    wire logic [31:0] dl_bit    = 32'(ack_bad)
                                  << uncorr_err_pkg::BIT_DL_PROTOCOL;
    wire logic [31:0] ev_bits   = err_event.valid ? err_event.bits : 32'h0;
    // unimplemented and reserved positions never latch
    wire logic [31:0] new_err   = (ev_bits | dl_bit)
                                  & uncorr_err_pkg::IMPL_BITS;
    wire logic [31:0] clr_bits  = wr_flags ? wdata : 32'h0;
    // a set in the same cycle as its clear wins
    assign flags_next = (flags_reg & ~clr_bits)
                        | new_err;

    // first error: nothing logged yet and this error logs headers
    wire logic hdr_take = (flags_reg == uncorr_err_pkg::FLAGS_RESET)
                          && err_event.valid
                          && |(new_err & uncorr_err_pkg::HDR_LOG_BITS);
    assign hdr_next = hdr_take ? err_event.header : hdr_reg;

    wire logic [31:0] unmasked = new_err & ~mask_reg;
    assign msg_next.fatal    = |(unmasked & sev_reg);
    assign msg_next.nonfatal = |(unmasked & ~sev_reg);

    // writable bits only; reserved and read-only ones keep constants
    assign mask_next = wr_mask
                       ? (wdata & uncorr_err_pkg::IMPL_BITS)
                       : mask_reg;
    assign sev_next  = wr_sev
                       ? ((wdata & uncorr_err_pkg::IMPL_BITS)
                          | uncorr_err_pkg::SEV_RO_ONE) : sev_reg;

    //--------------------------------------------------------------------
    // interrupt status: latched until ordinary reset, write one to clear, set wins
    //--------------------------------------------------------------------
    wire logic [1:0] irq_set = {msg_next.nonfatal, msg_next.fatal};
    wire logic [1:0] irq_clr = wr_ists ? wdata[1:0] : 2'h0;
    assign irq_sts_next = (irq_sts_reg & ~irq_clr) | irq_set;
    wire logic irq_next = |(irq_sts_next & (wr_imsk ? wdata[1:0]
                                                    : irq_msk_reg));

    //--------------------------------------------------------------------
    // read mux
    //--------------------------------------------------------------------
    always_comb
    begin
        rdata_next = 32'h0;
        if (rd_stb)
        begin
            if (sel_flags)
                rdata_next = flags_reg;
            else if (sel_mask)
                rdata_next = mask_reg;
            else if (sel_sev)
                rdata_next = sev_reg;
            else if (sel_ists)
                rdata_next = {30'h0, irq_sts_reg};
            else if (sel_imsk)
                rdata_next = {30'h0, irq_msk_reg};
            else
            begin
                for (int i = 0; i < HDRW; i++)
                begin
                    if (sel_hdr[i])
                        rdata_next = hdr_word[i];
                end
            end
        end
    end

    //--------------------------------------------------------------------
    // sticky registers: cleared only at power-on
    //--------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge pwr_rstn)
    begin
        if (!pwr_rstn)
        begin
            flags_reg <= uncorr_err_pkg::FLAGS_RESET;
            mask_reg  <= uncorr_err_pkg::MASK_RESET;
            sev_reg   <= uncorr_err_pkg::SEV_RESET;
            hdr_reg   <= '0;
        end
        else
        begin
            flags_reg <= flags_next;
            mask_reg  <= mask_next;
            sev_reg   <= sev_next;
            hdr_reg   <= hdr_next;
        end
    end

    //--------------------------------------------------------------------
    // ordinary registers
    //--------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_reg   <= 32'h0;
            msg_reg     <= '0;
            irq_sts_reg <= uncorr_err_pkg::IRQ_RESET;
            irq_msk_reg <= uncorr_err_pkg::IRQ_RESET;
            irq_reg     <= 1'b0;
        end
        else
        begin
            rdata_reg   <= rdata_next;
            msg_reg     <= msg_next;
            irq_sts_reg <= irq_sts_next;
            irq_msk_reg <= wr_imsk ? wdata[1:0] : irq_msk_reg;
            irq_reg     <= irq_next;
        end
    end

    assign rdata   = rdata_reg;
    assign err_msg = msg_reg;
    assign irq     = irq_reg;

    //--------------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn || !pwr_rstn);

    // bit positions watched below
    localparam int POISON_POS = uncorr_err_pkg::BIT_POISONED;
    localparam int DLP_POS    = uncorr_err_pkg::BIT_DL_PROTOCOL;
    localparam int TRAIN_POS  = uncorr_err_pkg::BIT_TRAINING;
    localparam int ECRC_POS   = uncorr_err_pkg::BIT_ECRC;

    wire logic poison_in = err_event.valid
                           && err_event.bits[uncorr_err_pkg::BIT_POISONED];

    a_poison_sets_flag: assert property (
        poison_in |=> flags_reg[POISON_POS])
        else $error("poisoned packet did not set flag 12");

    a_dlp_sets_flag: assert property (
        ack_bad |=> flags_reg[DLP_POS])
        else $error("bad ack sequence did not set flag 4");

    a_zero_write_keeps: assert property (
        wr_flags && new_err == 32'h0 && wdata == 32'h0
        |=> flags_reg == $past(flags_reg))
        else $error("writing zero changed the flags");

    a_one_write_clears: assert property (
        wr_flags && wdata[POISON_POS] && !new_err[POISON_POS]
        |=> !flags_reg[POISON_POS])
        else $error("writing one did not clear flag 12");

    a_ro_bits_fixed: assert property (
        flags_reg[TRAIN_POS] == 1'b0 && mask_reg[TRAIN_POS] == 1'b0
        && sev_reg[TRAIN_POS] == 1'b1)
        else $error("bit 0 of flags, mask or severity changed");

    a_ecrc_reads_zero: assert property (
        mask_reg[ECRC_POS] == 1'b0 && sev_reg[ECRC_POS] == 1'b0)
        else $error("ECRC mask or severity bit became set");

    a_reserved_zero: assert property (
        ((flags_reg | mask_reg) & ~uncorr_err_pkg::IMPL_BITS) == 32'h0)
        else $error("reserved bit became set");

    a_masked_silent: assert property (
        new_err != 32'h0 && (new_err & ~mask_reg) == 32'h0
        |=> !err_msg.fatal && !err_msg.nonfatal)
        else $error("masked error produced a message");

    a_masked_logged: assert property (
        (new_err & mask_reg) != 32'h0
        |=> (flags_reg & $past(new_err)) == $past(new_err))
        else $error("masked error was not logged");

    a_fatal_select: assert property (
        (new_err & ~mask_reg & sev_reg) != 32'h0 |=> err_msg.fatal)
        else $error("fatal-selected error sent no fatal message");

    a_nonfatal_select: assert property (
        (new_err & ~mask_reg & ~sev_reg) != 32'h0 |=> err_msg.nonfatal)
        else $error("nonfatal error sent no nonfatal message");

    a_header_first: assert property (
        hdr_take |=> hdr_reg == $past(err_event.header) ##1 $stable(hdr_reg)
                     || flags_reg == 32'h0)
        else $error("first error header not captured");

    a_irq_follows: assert property (
        (irq_sts_reg & irq_msk_reg) != 2'h0 && !wr_ists && !wr_imsk
        |=> irq)
        else $error("unmasked interrupt status without interrupt");

    a_flags_sticky: assert property (
        disable iff (!pwr_rstn)
        !wr_flags && new_err == 32'h0 |=> $stable(flags_reg))
        else $error("flags changed with no event and no clear");

    a_mask_sticky: assert property (
        disable iff (!pwr_rstn)
        !wr_mask |=> $stable(mask_reg))
        else $error("report mask changed with no write");

    a_sev_sticky: assert property (
        disable iff (!pwr_rstn)
        !wr_sev |=> $stable(sev_reg))
        else $error("fatal select changed with no write");

    a_mask_write: assert property (
        wr_mask
        |=> mask_reg == ($past(wdata) & uncorr_err_pkg::IMPL_BITS))
        else $error("report mask write not taken on implemented bits");

    a_sev_write: assert property (
        wr_sev
        |=> (sev_reg & uncorr_err_pkg::IMPL_BITS)
            == ($past(wdata) & uncorr_err_pkg::IMPL_BITS))
        else $error("fatal select write not taken");

    a_sev_reserved: assert property (
        (sev_reg & ~uncorr_err_pkg::IMPL_BITS)
        == uncorr_err_pkg::SEV_RO_ONE)
        else $error("fatal select reserved bit became set");

    a_set_wins: assert property (
        wr_flags && (wdata & new_err) != 32'h0
        |=> (flags_reg & $past(new_err)) == $past(new_err))
        else $error("clear in the cycle of a new error lost the error");

    a_clear_exact: assert property (
        wr_flags && new_err == 32'h0
        |=> flags_reg == ($past(flags_reg) & ~$past(wdata)))
        else $error("write one to clear left wrong flags");

    a_hdr_hold: assert property (
        !hdr_take |=> $stable(hdr_reg))
        else $error("header log changed after the first error");

    a_last_acked_ok: assert property (
        ack_nak.valid && ack_nak.seq == ack_nak.acked_seq |-> !ack_bad)
        else $error("ack of the last acked packet flagged as error");

    a_msg_needs_err: assert property (
        new_err == 32'h0 |=> !err_msg.fatal && !err_msg.nonfatal)
        else $error("error message without a new error");

    a_rdata_idle: assert property (
        !rd_stb |=> rdata == 32'h0)
        else $error("read data not zero outside a read");

    a_irq_sts_set: assert property (
        irq_set != 2'h0
        |=> (irq_sts_reg & $past(irq_set)) == $past(irq_set))
        else $error("sent message did not set interrupt status");

    a_irq_sts_clear: assert property (
        wr_ists && irq_set == 2'h0
        |=> (irq_sts_reg & $past(wdata[1:0])) == 2'h0)
        else $error("interrupt status write one did not clear");

    a_irq_mask_write: assert property (
        wr_imsk |=> irq_msk_reg == $past(wdata[1:0]))
        else $error("interrupt mask write not taken");

    a_irq_low: assert property (
        (irq_sts_reg & irq_msk_reg) == 2'h0 && irq_set == 2'h0
        && !wr_imsk |=> !irq)
        else $error("interrupt without unmasked status");

    c_poison_fatal: cover property (poison_in ##1 err_msg.fatal);
    c_dlp_logged: cover property (ack_bad ##1 flags_reg[DLP_POS]);
    c_masked_err: cover property ((new_err & mask_reg) != 32'h0);
    c_clear_flag: cover property (wr_flags && wdata[POISON_POS]
                                  && flags_reg[POISON_POS]);
    c_set_wins: cover property (wr_flags
                                && (wdata & new_err) != 32'h0);

endmodule
`default_nettype wire

//--- uncorr_link_model.sv
// link-side model that raises error events and ack/nak reports
`timescale 1ns/10ps
`default_nettype none
module uncorr_link_model
(
    // clock
    input  wire logic                        clk_sys,
    // reports towards the block
    output var uncorr_err_pkg::err_event_type err_event,
    output var uncorr_err_pkg::ack_nak_type   ack_nak
);
    initial
    begin
        err_event = '0;
        ack_nak   = '0;
    end

    // one-cycle pulse; payload inverts afterwards so stale data never match
    task automatic send_err(input logic [31:0] b, input logic [127:0] h);
        @(posedge clk_sys);
        err_event <= '{valid: 1'b1, bits: b, header: h};
        @(posedge clk_sys);
        err_event <= '{valid: 1'b0, bits: ~b, header: ~h};
    endtask

    task automatic send_ack(input logic [11:0] s, a, n);
        @(posedge clk_sys);
        ack_nak <= '{valid: 1'b1, seq: s, acked_seq: a, next_tx_seq: n};
        @(posedge clk_sys);
        ack_nak <= '{valid: 1'b0, seq: ~s, acked_seq: ~a, next_tx_seq: ~n};
    endtask
endmodule
`default_nettype wire
